/* design/epf_core.sv */
// Purpose: phase power products, smoothing, summation and power to pulse conversion
// Assumes: samples arrive on MCLK with a one-cycle valid; select pins are asynchronous
// Notes:   all state lives in one struct; one comb process, one clocked process
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [RULE_01] mode pin high arithmetic, low absolute sum
// [RULE_02] absolute mode counts every phase positive
// [RULE_03] phase reverse flags still work in absolute mode
// [RULE_04] low-rate energy outputs are active-high pulses
// [RULE_05] low-rate rate follows long-term average power
// [RULE_06] rate equals 6.181 power base over vref squared
// [RULE_07] three select pins choose the base frequency
// [RULE_08] base frequency divided down from master clock
// [RULE_09] calibration multiple chosen by the select pins
// [RULE_10] calibration output averages over shorter interval
// [RULE_11] delta mode uses a-c and b-c voltages
// [RULE_12] each phase product is low-pass filtered
// [RULE_13] alternating 120 ms pulses, halved below 550 ms
// [RULE_14] calibration pulses 90 ms, half period below 190 ms
// [RULE_15] no pulses below the no-load floor
// [RULE_16] total reverse flag changes only at calibration pulse
// [RULE_17] accumulate per tick, pulse on crossing, keep remainder
// [RULE_18] calibration threshold smaller by the selected multiple
module epf_core #(
	parameter longint unsigned TICK_DIV   = epf_pkg::TICK_DIV_SCALE,	// tick divider scale
	parameter longint unsigned PW_LO      = epf_pkg::PW_LO_CYC,	// low-rate pulse width
	parameter longint unsigned PER_LO     = epf_pkg::PER_LO_CYC,	// low-rate period limit
	parameter longint unsigned PW_CF      = epf_pkg::PW_CF_CYC,	// calibration pulse width
	parameter longint unsigned PER_CF     = epf_pkg::PER_CF_CYC	// calibration period limit
) (
	input  wire logic                  MCLK,
	input  wire logic                  RST_N,
	input  wire epf_pkg::epf_samples_t SAMPLES,
	input  wire logic                  SAMPLE_VALID,
	input  wire logic                  SUM_MODE_SELECT,
	input  wire logic                  CAL_SCALE_SELECT,
	input  wire logic                  RATE_SELECT_HI,
	input  wire logic                  RATE_SELECT_LO,
	input  wire logic                  DELTA_MODE,
	output logic                       ENERGY_PULSE_A,
	output logic                       ENERGY_PULSE_B,
	output logic                       CALIBRATION_PULSE,
	output logic                       REVERSE_POWER_FLAG,
	output logic [2:0]                 PHASE_REVERSE
);
	import epf_pkg::*;

	// complete state of the block
	typedef struct packed {
		logic [SY_W-1:0] sync1;	// first synchroniser stage
		logic [SY_W-1:0] sync2;	// second synchroniser stage
		epf_pwr_t [2:0]  lpf;	// smoothed phase powers
		epf_cnt_t        div_cnt;	// tick divider
		epf_acc_t        lo_acc;	// low-rate accumulator
		epf_acc_t        cf_acc;	// calibration accumulator
		logic            ab;	// next low-rate pulse goes to b
		epf_cnt_t        a_cnt;	// remaining high time of a
		epf_cnt_t        b_cnt;	// remaining high time of b
		epf_cnt_t        c_cnt;	// remaining high time of calibration
		epf_cnt_t        a_per;	// running period of a
		epf_cnt_t        a_last;	// last full period of a, 0 = none yet
		epf_cnt_t        c_per;	// running calibration period
		epf_cnt_t        c_last;	// last calibration period
		epf_out_t        out;	// registered outputs
	} epf_state_t;

	epf_state_t st;	// current state
	epf_state_t next_st;	// next state

	// signed product of a voltage and a current; operands are widened
	// first so the 33-bit product is never cut to the operand width
	function automatic epf_pwr_t mul(input logic signed [16:0] v, input logic signed [15:0] i);
		mul = epf_pwr_t'(v) * epf_pwr_t'(i);
	endfunction

	// first-order smoothing step
	function automatic epf_pwr_t lpf_step(input epf_pwr_t x, input epf_pwr_t y);
		logic signed [34:0] d;
		d = 35'(x) - 35'(y);
		lpf_step = y + epf_pwr_t'(d >>> LPF_SHIFT);
	endfunction

	// magnitude of a phase power
	function automatic epf_tot_t absv(input epf_pwr_t p);
		absv = p[33] ? -epf_tot_t'(p) : epf_tot_t'(p);
	endfunction

	// pulse width: full width, or half the last period when that is short
	function automatic epf_cnt_t width(input epf_cnt_t last, input longint unsigned lim,
					input longint unsigned full);
		width = (last != 32'h0 && 64'(last) < lim) ? (last >> 1) : 32'(full);
	endfunction

	// saturating period counter
	function automatic epf_cnt_t per_inc(input epf_cnt_t c);
		per_inc = (c == 32'hffffffff) ? c : c + 32'h1;
	endfunction

	// base frequency in centi-hertz for {scale, hi, lo}
	function automatic longint unsigned base_centi(input logic [2:0] s);
		unique case (s)
			3'h0: base_centi = 64'd230;
			3'h4: base_centi = 64'd461;
			3'h1: base_centi = 64'd115;
			3'h5: base_centi = 64'd461;
			3'h2: base_centi = 64'd522;
			3'h6: base_centi = 64'd115;
			3'h3: base_centi = 64'd58;
			3'h7: base_centi = 64'd58;
		endcase
	endfunction

	// calibration multiple for {scale, hi, lo}
	function automatic longint unsigned cal_mult(input logic [2:0] s);
		unique case (s)
			3'h0: cal_mult = 64'd16;
			3'h4: cal_mult = 64'd8;
			3'h1: cal_mult = 64'd32;
			3'h5: cal_mult = 64'd16;
			3'h2: cal_mult = 64'd160;
			3'h6: cal_mult = 64'd16;
			3'h3: cal_mult = 64'd32;
			3'h7: cal_mult = 64'd16;
		endcase
	endfunction

	logic [2:0]         sel;	// synchronised rate selection
	logic               arith;	// arithmetic sum selected
	epf_pwr_t [2:0]     prod;	// raw phase products
	epf_tot_t           total;	// summed power
	epf_tot_t           mag;	// magnitude of the sum
	epf_acc_t           inc;	// per-tick increment after no-load floor
	epf_cnt_t           tick_per;	// cycles per conversion tick
	logic               tick;	// conversion tick
	epf_acc_t           lo_sum;	// low-rate accumulator plus increment
	epf_acc_t           cf_sum;	// calibration accumulator plus increment
	epf_acc_t           lo_half;	// low-rate half-period threshold
	epf_acc_t           cf_thr;	// calibration threshold
	logic               lo_start;	// low-rate crossing
	logic               cf_start;	// calibration crossing
	logic               rev_cond;	// reverse condition to latch
	logic               a_start;	// pulse begins on a
	logic               b_start;	// pulse begins on b

	// power path, tick divider and conversion
	always_comb begin
		next_st = st;
		// pins pass two flops before use
		next_st.sync1 = {DELTA_MODE, RATE_SELECT_LO, RATE_SELECT_HI, CAL_SCALE_SELECT,
				SUM_MODE_SELECT};
		next_st.sync2 = st.sync1;
		sel   = {st.sync2[SY_SCF], st.sync2[SY_S1], st.sync2[SY_S0]};
		arith = st.sync2[SY_MODE];

		// products; delta mode references phase c voltage, c channel unused
		if (st.sync2[SY_DELTA]) begin	// [RULE_11]
			prod[0] = mul(17'(SAMPLES.volt[0]) - 17'(SAMPLES.volt[2]), SAMPLES.curr[0]);
			prod[1] = mul(17'(SAMPLES.volt[1]) - 17'(SAMPLES.volt[2]), SAMPLES.curr[1]);
			prod[2] = '0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				prod[k] = mul(17'(SAMPLES.volt[k]), SAMPLES.curr[k]);
			end
		end
		// smoothing removes the twice-line ripple per phase
		if (SAMPLE_VALID) begin
			for (int k = 0; k < 3; k++) begin
				next_st.lpf[k] = lpf_step(prod[k], st.lpf[k]);	// [RULE_12]
			end
		end

		// sum of phases, arithmetic or absolute
		if (arith) begin
			total = epf_tot_t'(st.lpf[0]) + epf_tot_t'(st.lpf[1]) + epf_tot_t'(st.lpf[2]);	// [RULE_01]
		end else begin
			total = absv(st.lpf[0]) + absv(st.lpf[1]) + absv(st.lpf[2]);	// [RULE_02]
		end
		mag = total[35] ? -total : total;
		// below the floor nothing accumulates, so no output can pulse
		inc = (64'(mag) < NOLOAD_MIN) ? '0 : epf_acc_t'(mag);	// [RULE_15]

		// tick rate is base frequency times 2^TICK_SHIFT, divided from MCLK
		tick_per = 32'(TICK_DIV / base_centi(sel));	// [RULE_07] [RULE_08]
		tick = (st.div_cnt >= tick_per - 32'h1);
		// restart on the tick, so one tick period is exactly tick_per cycles
		next_st.div_cnt = tick ? '0 : st.div_cnt + 32'h1;

		// accumulators; threshold encodes gain over vref squared
		lo_half = epf_acc_t'(LO_THRESH >> 1);	// [RULE_06]
		cf_thr  = epf_acc_t'(LO_THRESH / cal_mult(sel));	// [RULE_09] [RULE_18]
		lo_sum = st.lo_acc + inc;
		cf_sum = st.cf_acc + inc;
		// a leftover remainder must not fire while the load sits below the floor
		lo_start = tick && (inc != '0) && (lo_sum >= lo_half);	// [RULE_05] [RULE_15]
		cf_start = tick && (inc != '0) && (cf_sum >= cf_thr);	// [RULE_10] [RULE_15]
		if (tick) begin
			next_st.lo_acc = lo_start ? lo_sum - lo_half : lo_sum;	// [RULE_17]
			next_st.cf_acc = cf_start ? cf_sum - cf_thr : cf_sum;	// [RULE_18]
		end

		// low-rate pulses alternate between a and b every half period
		a_start = lo_start && !st.ab;	// [RULE_13]
		b_start = lo_start && st.ab;
		if (lo_start) begin
			next_st.ab = !st.ab;
		end
		next_st.a_per = a_start ? 32'h1 : per_inc(st.a_per);
		if (a_start) begin
			next_st.a_last = st.a_per;
		end
		// width follows the period measured on a
		if (a_start) begin
			next_st.a_cnt = width(st.a_per, PER_LO, PW_LO);	// [RULE_13]
		end else if (st.a_cnt != 32'h0) begin
			next_st.a_cnt = st.a_cnt - 32'h1;
		end
		if (b_start) begin
			next_st.b_cnt = width(st.a_last, PER_LO, PW_LO);	// [RULE_13]
		end else if (st.b_cnt != 32'h0) begin
			next_st.b_cnt = st.b_cnt - 32'h1;
		end

		// calibration pulse
		next_st.c_per = cf_start ? 32'h1 : per_inc(st.c_per);
		if (cf_start) begin
			next_st.c_last = st.c_per;
			next_st.c_cnt  = width(st.c_per, PER_CF, PW_CF);	// [RULE_14]
		end else if (st.c_cnt != 32'h0) begin
			next_st.c_cnt = st.c_cnt - 32'h1;
		end

		// per-phase sign shows in either mode
		for (int k = 0; k < 3; k++) begin
			next_st.out.phase_rev[k] = st.lpf[k][33];	// [RULE_03]
		end
		// absolute mode flags any negative phase, arithmetic the sum
		rev_cond = arith ? total[35] : (|next_st.out.phase_rev);	// [RULE_03]
		if (cf_start) begin
			next_st.out.rev = rev_cond;	// [RULE_16]
		end
		next_st.out.pulse_a = (next_st.a_cnt != 32'h0);	// [RULE_04]
		next_st.out.pulse_b = (next_st.b_cnt != 32'h0);	// [RULE_04]
		next_st.out.cal     = (next_st.c_cnt != 32'h0);
	end

	// single state register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops
	assign ENERGY_PULSE_A     = st.out.pulse_a;
	assign ENERGY_PULSE_B     = st.out.pulse_b;
	assign CALIBRATION_PULSE  = st.out.cal;
	assign REVERSE_POWER_FLAG = st.out.rev;
	assign PHASE_REVERSE      = st.out.phase_rev;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// arithmetic sum equals the absolute sum exactly when no phase is negative
	chk_sum_arith: assert property (arith |-> ((total ==	// [RULE_01]
		absv(st.lpf[0]) + absv(st.lpf[1]) + absv(st.lpf[2])) ==
		!(st.lpf[0][33] || st.lpf[1][33] || st.lpf[2][33])))
		else $error("arithmetic sum wrong");
	chk_abs_positive: assert property (!arith |-> !total[35])	// [RULE_02]
		else $error("absolute sum negative");
	chk_phase_sign: assert property (##1 PHASE_REVERSE ==	// [RULE_03]
		{$past(st.lpf[2][33]), $past(st.lpf[1][33]), $past(st.lpf[0][33])})
		else $error("phase reverse flag mismatch");
	chk_rev_hold: assert property (!cf_start |=> $stable(REVERSE_POWER_FLAG))	// [RULE_16]
		else $error("reverse flag moved without calibration pulse");
	chk_rev_load: assert property (cf_start |=> REVERSE_POWER_FLAG == $past(rev_cond))	// [RULE_16]
		else $error("reverse flag not loaded");
	chk_noload_hold: assert property (tick && inc == '0 |=>	// [RULE_15]
		$stable(st.lo_acc) && $stable(st.cf_acc))
		else $error("accumulated below no-load floor");
	chk_ab_alternate: assert property (a_start |=> ENERGY_PULSE_A && st.ab)	// [RULE_13]
		else $error("low-rate pulses not alternating");
	chk_b_follow: assert property (b_start |=> ENERGY_PULSE_B && !st.ab)	// [RULE_13]
		else $error("low-rate b pulse not alternating");
	chk_noload_quiet: assert property (inc == '0 && !CALIBRATION_PULSE && !ENERGY_PULSE_A &&	// [RULE_15]
		!ENERGY_PULSE_B |=> !CALIBRATION_PULSE && !ENERGY_PULSE_A && !ENERGY_PULSE_B)
		else $error("pulse started below no-load floor");
	chk_cf_thresh: assert property (cf_start |-> cf_sum >= cf_thr && tick)	// [RULE_18]
		else $error("calibration pulse without crossing");
	chk_tick_div: assert property (tick |=> st.div_cnt == '0 ##1 !tick || tick_per == 32'h1)	// [RULE_08]
		else $error("tick divider restart wrong");
	chk_remainder: assert property (lo_start |=> st.lo_acc == $past(lo_sum) - $past(lo_half))	// [RULE_17]
		else $error("remainder not kept");

	cov_pulse_a: cover property (a_start);
	cov_pulse_b: cover property (b_start);
	cov_cal: cover property (cf_start ##1 CALIBRATION_PULSE);
	cov_rev: cover property ($rose(REVERSE_POWER_FLAG));
	cov_delta: cover property (st.sync2[SY_DELTA] && cf_start);
endmodule

`default_nettype wire

/* design/epf_pkg.sv */
// Purpose: constants and types for the energy sum to pulse frequency back end
// Assumes: 16-bit signed sample codes, full scale code equals 0.5 V at the pins
// Notes:   counts of cycles above 4096 become top-level parameters with these defaults
package epf_pkg;
	// master clock
	localparam longint unsigned MCLK_HZ      = 64'd200000000;
	// pulse timing in milliseconds and the derived cycle counts
	localparam longint unsigned PW_LO_MS     = 64'd120;
	localparam longint unsigned PER_LO_MS    = 64'd550;
	localparam longint unsigned PW_CF_MS     = 64'd90;
	localparam longint unsigned PER_CF_MS    = 64'd190;
	localparam longint unsigned PW_LO_CYC    = PW_LO_MS * (MCLK_HZ / 64'd1000);
	localparam longint unsigned PER_LO_CYC   = PER_LO_MS * (MCLK_HZ / 64'd1000);
	localparam longint unsigned PW_CF_CYC    = PW_CF_MS * (MCLK_HZ / 64'd1000);
	localparam longint unsigned PER_CF_CYC   = PER_CF_MS * (MCLK_HZ / 64'd1000);
	// conversion ticks run at base frequency times 2^TICK_SHIFT
	localparam int unsigned     TICK_SHIFT   = 10;
	// divider scale: cycles of one tick times the base frequency in centi-hertz
	localparam longint unsigned TICK_DIV_SCALE = (MCLK_HZ * 64'd100) >> TICK_SHIFT;
	// transfer gain 6.181 in thousandths, nominal reference in millivolts
	localparam longint unsigned GAIN_MILLI   = 64'd6181;
	localparam longint unsigned VREF_MV      = 64'd2400;
	// threshold of one full output period (code^2 units, 4 = 1/(0.5 V)^2)
	localparam longint unsigned LO_THRESH    =
		((64'd1 << (30 + TICK_SHIFT)) * ((VREF_MV * VREF_MV * 64'd4) / 64'd1000)) / GAIN_MILLI;
	// full-scale summed power and the no-load floor of 0.0075 percent
	localparam longint unsigned FS_SUM       = 64'd3 << 30;
	localparam longint unsigned NOLOAD_PPM   = 64'd75;
	localparam longint unsigned NOLOAD_MIN   = (FS_SUM * NOLOAD_PPM) / 64'd1000000;
	// low-pass smoothing shift, applied at each input sample
	localparam int unsigned     LPF_SHIFT    = 8;
	// synchroniser bit positions
	localparam int unsigned     SY_MODE      = 0;
	localparam int unsigned     SY_SCF       = 1;
	localparam int unsigned     SY_S1        = 2;
	localparam int unsigned     SY_S0        = 3;
	localparam int unsigned     SY_DELTA     = 4;
	localparam int unsigned     SY_W         = 5;

	typedef logic signed [15:0] epf_code_t;	// one adc sample code
	typedef logic signed [33:0] epf_pwr_t;	// per-phase power
	typedef logic signed [35:0] epf_tot_t;	// summed power
	typedef logic [55:0]        epf_acc_t;	// pulse accumulators
	typedef logic [31:0]        epf_cnt_t;	// timing counters

	// one set of simultaneous samples
	typedef struct packed {
		epf_code_t [2:0] volt;	// phase voltages, index 0 = phase a
		epf_code_t [2:0] curr;	// phase currents
	} epf_samples_t;

	// output group
	typedef struct packed {
		logic       pulse_a;	// low-rate output a
		logic       pulse_b;	// low-rate output b
		logic       cal;	// calibration output
		logic       rev;	// total reverse power
		logic [2:0] phase_rev;	// per-phase negative power
	} epf_out_t;
endpackage

/* tb/epf_counter.sv */
// Purpose: impulse counter and calibration counter standing at the pulse outputs
// Assumes: pulses are sampled on MCLK; clr zeroes the counts and alt_err
// Notes:   measures width of the last a and calibration pulses, and the calibration rise-to-rise period
`timescale 1ns/10ps
`default_nettype none
module epf_counter (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        clr,
	input  wire logic        pulse_a,
	input  wire logic        pulse_b,
	input  wire logic        cal,
	output logic [31:0]      ab_cnt,
	output logic [31:0]      cf_cnt,
	output logic [31:0]      cf_width,
	output logic [31:0]      cf_period,
	output logic [31:0]      a_width,
	output logic             alt_err
);
	logic [31:0] cf_run;	// cycles since the last calibration rise
	logic [31:0] cf_hi;	// high time of the running calibration pulse
	logic [31:0] a_hi;	// high time of the running low-rate a pulse
	logic        p_a;	// previous levels for edge detection
	logic        p_b;
	logic        p_cf;
	logic        last_b;	// last low-rate rise came from b
	// counts rises, checks a/b alternation, measures widths and periods
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{ab_cnt, cf_cnt, cf_width, cf_period, a_width} <= '0;
			{cf_run, cf_hi, a_hi, p_a, p_b, p_cf, alt_err} <= '0;
			last_b <= 1'b1;
		end else begin
			p_a <= pulse_a;
			p_b <= pulse_b;
			p_cf <= cal;
			cf_run <= cf_run + 1;
			cf_hi <= cal ? cf_hi + 1 : 32'h0;
			a_hi <= pulse_a ? a_hi + 1 : 32'h0;
			if (p_cf && !cal) cf_width <= cf_hi;
			if (p_a && !pulse_a) a_width <= a_hi;
			// a calibration rise closes one period
			if (cal && !p_cf) begin
				cf_cnt <= cf_cnt + 1;
				cf_period <= cf_run + 1;
				cf_run <= '0;
			end
			// a must follow b and b must follow a
			if (pulse_a && !p_a) begin
				ab_cnt <= ab_cnt + 1;
				if (!last_b) alt_err <= 1'b1;
				last_b <= 1'b0;
			end
			if (pulse_b && !p_b) begin
				ab_cnt <= ab_cnt + 1;
				if (last_b) alt_err <= 1'b1;
				last_b <= 1'b1;
			end
			// counts restart for a new measuring window
			if (clr) begin
				ab_cnt <= '0;
				cf_cnt <= '0;
				alt_err <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/test_energy_sum_to_pulse_frequency.sv */
// Purpose: self-checking bench for the power sum to pulse frequency core
// Assumes: shortened tick divider and pulse timing, sample sets with random gaps in valid
// Notes:   expected pulse counts are worked out from the transfer gain and tables
`timescale 1ns/10ps
`default_nettype none
module test_energy_sum_to_pulse_frequency;
	import epf_pkg::*;
	localparam int TDIV = 2000;	// tick divider scale used here
	logic         MCLK = 1'b0;
	logic         RST_N = 1'b0;
	epf_samples_t samples = '0;
	logic         valid = 1'b0;	// sample strobe, random gaps
	logic         mode, cal_scale_select, hi, lo, delta, clr;
	logic         pa, pb, cf, rev;
	logic [2:0]   ph_rev;
	logic [31:0]  ab_cnt, cf_cnt, cf_width, cf_period, a_width;
	logic         alt_err;
	epf_code_t    vset [3];	// voltage codes per phase
	epf_code_t    cset [3];	// current codes per phase
	int           err_count = 0;
	int           checked = 0;
	int           seed = 30;
	int           k;
	real          p;	// summed power in code squared
	int centi [8] = '{230, 115, 522, 58, 461, 461, 115, 58};	// base rate, index {scf,hi,lo}
	int mult [8] = '{16, 32, 160, 32, 8, 16, 16, 16};	// calibration multiple
	always #2.5 MCLK = ~MCLK;
	epf_core #(.TICK_DIV(64'(TDIV)), .PW_LO(64'd40), .PER_LO(64'd200), .PW_CF(64'd20),
		.PER_CF(64'd60)) i_epf_core (.MCLK(MCLK), .RST_N(RST_N), .SAMPLES(samples),
		.SAMPLE_VALID(valid), .SUM_MODE_SELECT(mode), .CAL_SCALE_SELECT(cal_scale_select),
		.RATE_SELECT_HI(hi), .RATE_SELECT_LO(lo), .DELTA_MODE(delta), .ENERGY_PULSE_A(pa),
		.ENERGY_PULSE_B(pb), .CALIBRATION_PULSE(cf), .REVERSE_POWER_FLAG(rev),
		.PHASE_REVERSE(ph_rev));
	epf_counter i_epf_counter (.mclk(MCLK), .rst_n(RST_N), .clr(clr), .pulse_a(pa),
		.pulse_b(pb), .cal(cf), .ab_cnt(ab_cnt), .cf_cnt(cf_cnt), .cf_width(cf_width),
		.cf_period(cf_period), .a_width(a_width), .alt_err(alt_err));
	// sample source: random gaps in valid, random jitter on the current codes
	always @(posedge MCLK) begin
		valid <= ($random(seed) & 3) != 0;
		for (int j = 0; j < 3; j++) begin
			samples.volt[j] <= vset[j];
			samples.curr[j] <= cset[j] + 16'($random(seed) & 3);
		end
	end
	// expected pulses in w cycles: rate = power * mult / (threshold * tick)
	function automatic real exp_pulses(int sel, real pw, int w, real m);
		return w * pw * m / (real'(LO_THRESH) * real'(TDIV / centi[sel]));	// whole cycles per tick
	endfunction
	task automatic check_eq(logic [31:0] got, logic [31:0] exp, string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask
	task automatic check_near(logic [31:0] got, real exp, string what);
		checked++;
		if ($isunknown(got) || real'(got) > exp * 1.25 + 2.0 || real'(got) < exp * 0.75 - 2.0) begin
			err_count++;
			$display("wrong value at %0t: %s got %0d expected about %0.1f", $time, what, got, exp);
		end
	endtask
	// select a rate, let pins and filters settle, then count over w cycles
	task automatic run(int sel, int settle, int w);
		{cal_scale_select, hi, lo} <= sel[2:0];
		repeat (settle) @(posedge MCLK);
		clr <= 1'b1;
		@(posedge MCLK);
		clr <= 1'b0;
		repeat (w) @(posedge MCLK);
	endtask
	task automatic set_all(int v, int c);
		for (int j = 0; j < 3; j++) begin
			vset[j] = 16'(v);
			cset[j] = 16'(c);
		end
	endtask
	task automatic wrap_up();
		$display("counts: %0d compared, %0d wrong", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// watchdog cuts a hang short
	initial begin
		repeat (96000) @(posedge MCLK);
		err_count++;
		wrap_up();
	end
	// main sequence
	initial begin
		{mode, cal_scale_select, hi, lo, delta, clr} <= 6'h00;
		set_all(100, 100);
		repeat (6) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		check_eq({28'h0, pa, pb, cf, rev}, 32'h0, "outputs after reset");
		run(0, 1500, 4000);
		check_eq(ab_cnt + cf_cnt, 32'h0, "pulses under no-load floor");
		check_eq({31'h0, |{i_epf_core.st.lo_acc, i_epf_core.st.cf_acc}}, 32'h0, "floor acc");
		$display("test no-load done");
		set_all(30000, 30000);
		p = 3.0 * 9.0e8;
		for (int s = 0; s < 8; s++) begin
			run(s, (s == 0) ? 1500 : 100, 4000);
			check_near(cf_cnt, exp_pulses(s, p, 4000, mult[s]), "cal count");
			if (cf_period >= 60) check_eq(cf_width, 32'd20, "cal width");
			else check_near(cf_width, cf_period / 2.0, "cal half width");
		end
		$display("test rate table done");
		run(2, 100, 20000);
		check_near(ab_cnt, exp_pulses(2, p, 20000, 2.0), "low-rate count");
		check_near(cf_cnt, real'(ab_cnt) * 80.0, "cal per low-rate");
		check_eq({31'h0, alt_err}, 32'h0, "a and b alternate");
		check_eq(a_width, 32'd40, "low-rate width");
		$display("test low-rate done");
		k = {$random(seed)} % 3;
		cset[k] = -16'sd30000;
		mode <= 1'b0;
		run(0, 2000, 5000);
		check_eq({29'h0, ph_rev}, 32'h1 << k, "phase reverse in absolute mode");
		check_near(cf_cnt, exp_pulses(0, p, 5000, 16.0), "absolute sum count");
		check_eq({31'h0, rev}, 32'h1, "reverse flag in absolute mode");
		mode <= 1'b1;
		run(0, 2000, 5000);
		check_near(cf_cnt, exp_pulses(0, p / 3.0, 5000, 16.0), "arithmetic sum count");
		check_eq({31'h0, rev}, 32'h0, "flag with positive total");
		cset[(k + 1) % 3] = -16'sd30000;
		run(0, 2000, 5000);
		check_eq({31'h0, rev}, 32'h1, "flag with negative total");
		check_near(cf_cnt, exp_pulses(0, p / 3.0, 5000, 16.0), "negative total count");
		$display("test sum modes done");
		set_all(30000, 30000);
		vset[2] = -16'sd15000;
		delta <= 1'b1;
		run(0, 2000, 5000);
		check_near(cf_cnt, exp_pulses(0, 2.7e9, 5000, 16.0), "delta count");
		$display("test delta done");
		wrap_up();
	end
endmodule
`default_nettype wire
